// ---- design/ebr_defines.vh ----
`ifndef EBR_DEFINES_VH
`define EBR_DEFINES_VH

// storage size and address layout
`define EBR_BITS 2048
`define EBR_ROWS 256
`define EBR_ROW_W 8
`define EBR_ADDR_W 11
`define EBR_LANE_LSB 8

// organisation codes: log2 of the number of lanes per row
`define EBR_ORG_256X8 2'h0
`define EBR_ORG_512X4 2'h1
`define EBR_ORG_1024X2 2'h2
`define EBR_ORG_2048X1 2'h3

// usage modes
`define EBR_MODE_SP 2'h0
`define EBR_MODE_ROM 2'h1
`define EBR_MODE_DP 2'h2
`define EBR_MODE_FIFO 2'h3

// reset values
`define EBR_DOUT_RST 8'h00

`endif

// ---- design/ebr_store.v ----
`timescale 1ns/1ns
`include "ebr_defines.vh"

module ebr_store #(
  parameter ROWS = `EBR_ROWS,
  parameter AW = 8
) (
  input wire clk_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_row_i,
  input wire [7:0] wr_mask_i,
  input wire [7:0] wr_dat_i,
  input wire [AW-1:0] rd_row_i,
  output wire [7:0] rd_dat_o
);

  // row array, eight bits a row, no reset on the cells
  reg [7:0] mem [0:ROWS-1];

  // bit-masked write so narrow words touch only their lane
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_row_i] <= (mem[wr_row_i] & ~wr_mask_i) | (wr_dat_i & wr_mask_i);
    end
  end

  // flow-through read, registered outside when selected
  assign rd_dat_o = mem[rd_row_i];

endmodule // ebr_store

// ---- design/ebr_top.v ----
// Operation
// - block stores 2048 bits; usable as single-port, rom, dual-port or fifo storage
// - ram organisations 256x8, 512x4, 1024x2 or 2048x1 selectable
// - input and output ports carry storage registers for synchronous access
// - write strobe generated inside, timed by the clock edge
// - all registers run on clk_i; the output register may instead advance on synchronised rising edges of a separate output clock
// - data-in, data-out and address/write-enable registering each selectable
// - wider memories by parallel blocks sharing one address
// - blocks cascade up to 2048 words with no change in timing
// - rom pattern loaded at configuration, then used as a lookup table
`timescale 1ns/1ns
`include "ebr_defines.vh"

module ebr_top #(
  parameter [1:0] ORG = `EBR_ORG_256X8,
  parameter [1:0] MODE = `EBR_MODE_SP,
  parameter REG_DIN = 1,
  parameter REG_ADDR_WE = 1,
  parameter REG_DOUT = 1,
  parameter OUT_CLK_SEP = 0
) (
  input wire clk_i,
  input wire nrst_i,
  input wire out_clk_i,
  input wire cs_i,
  input wire we_i,
  input wire [10:0] wr_addr_i,
  input wire [10:0] rd_addr_i,
  input wire [7:0] wr_data_i,
  input wire cfg_load_i,
  input wire [7:0] cfg_addr_i,
  input wire [7:0] cfg_data_i,
  output wire [7:0] rd_data_o
);

  // word width of the chosen organisation
  localparam WBITS = 8 >> ORG;

  // lane mask of a word within its row
  function [7:0] ebr_lane_mask;
    input [1:0] org;
    input [2:0] lane;
    begin
      case (org)
        `EBR_ORG_256X8: ebr_lane_mask = 8'hff;
        `EBR_ORG_512X4: ebr_lane_mask = 8'h0f << {lane[0], 2'h0};
        `EBR_ORG_1024X2: ebr_lane_mask = 8'h03 << {lane[1:0], 1'h0};
        default: ebr_lane_mask = 8'h01 << lane;
      endcase
    end
  endfunction

  // lane number of an address, only the bits the organisation uses
  function [2:0] ebr_lane;
    input [1:0] org;
    input [10:0] addr;
    begin
      case (org)
        `EBR_ORG_256X8: ebr_lane = 3'h0;
        `EBR_ORG_512X4: ebr_lane = {2'h0, addr[8]};
        `EBR_ORG_1024X2: ebr_lane = {1'h0, addr[9:8]};
        default: ebr_lane = addr[10:8];
      endcase
    end
  endfunction

  reg cs_q;
  reg we_q;
  reg [10:0] wa_q;
  reg [10:0] ra_q;
  reg [7:0] din_q;
  reg [7:0] dout_q;
  reg oclk_s1_q;
  reg oclk_s2_q;
  reg oclk_s3_q;

  wire cs_e;
  wire we_e;
  wire [10:0] wa_e;
  wire [10:0] ra_e;
  wire [7:0] din_e;
  wire [7:0] din_rep;
  wire [7:0] row_dat;
  wire [7:0] rd_word;
  wire user_wr;
  wire mem_wr;
  wire [7:0] mem_wa;
  wire [7:0] mem_mask;
  wire [7:0] mem_wd;
  wire out_tick;

  // chip select and write enable input registers
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_q <= 1'b0;
      we_q <= 1'b0;
    end else begin
      cs_q <= cs_i;
      we_q <= we_i;
    end
  end

  // write address register, same path as the strobe so both line up
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wa_q <= 11'h000;
    end else begin
      wa_q <= wr_addr_i;
    end
  end

  // read address register for the rom, dual-port and fifo uses
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ra_q <= 11'h000;
    end else begin
      ra_q <= rd_addr_i;
    end
  end

  // write data input register
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      din_q <= 8'h00;
    end else begin
      din_q <= wr_data_i;
    end
  end

  // path selection: registered or flow-through per path
  // write side first, read address follows the write address in single-port use
  assign cs_e = (REG_ADDR_WE != 0) ? cs_q : cs_i;
  assign we_e = (REG_ADDR_WE != 0) ? we_q : we_i;
  assign wa_e = (REG_ADDR_WE != 0) ? wa_q : wr_addr_i;
  assign ra_e = (MODE == `EBR_MODE_SP) ? wa_e :
                ((REG_ADDR_WE != 0) ? ra_q : rd_addr_i);
  assign din_e = (REG_DIN != 0) ? din_q : wr_data_i;

  // replicate the narrow word into every lane of a row
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rep
      assign din_rep[gi] = din_e[gi % WBITS];
    end
  endgenerate

  // internal strobe: one write per clock edge while enabled and selected, never in rom use
  assign user_wr = we_e & cs_e & (MODE != `EBR_MODE_ROM);

  // configuration load writes whole rows and takes priority
  assign mem_wr = cfg_load_i | user_wr;
  assign mem_wa = cfg_load_i ? cfg_addr_i : wa_e[7:0];
  assign mem_mask = cfg_load_i ? 8'hff : ebr_lane_mask(ORG, ebr_lane(ORG, wa_e));
  assign mem_wd = cfg_load_i ? cfg_data_i : din_rep;

  // 256 rows of 8 bits hold all 2048 bits
  ebr_store #(
    .ROWS(`EBR_ROWS),
    .AW(`EBR_ROW_W)
  ) u_store (
    .clk_i(clk_i),
    .wr_en_i(mem_wr),
    .wr_row_i(mem_wa),
    .wr_mask_i(mem_mask),
    .wr_dat_i(mem_wd),
    .rd_row_i(ra_e[7:0]),
    .rd_dat_o(row_dat)
  );

  // lane of the read word within its row
  wire [2:0] rd_lane;
  wire [7:0] word_sel;
  assign rd_lane = ebr_lane(ORG, ra_e);

  // pick the addressed word bit by bit, unused upper bits read zero
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pick
      if (gi < WBITS) begin : g_used
        assign word_sel[gi] = row_dat[rd_lane * WBITS + gi];
      end else begin : g_zero
        assign word_sel[gi] = 1'b0;
      end
    end
  endgenerate

  // deselected block reads zero so cascaded outputs can be ored
  assign rd_word = cs_e ? word_sel : 8'h00;

  // output clock passes two flip-flops before anything reads it
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oclk_s1_q <= 1'b0;
      oclk_s2_q <= 1'b0;
    end else begin
      oclk_s1_q <= out_clk_i;
      oclk_s2_q <= oclk_s1_q;
    end
  end

  // last synchronised level, kept for rising edge detection
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oclk_s3_q <= 1'b0;
    end else begin
      oclk_s3_q <= oclk_s2_q;
    end
  end

  // output register advances on the output clock rising edge when separate
  assign out_tick = (OUT_CLK_SEP != 0) ? (oclk_s2_q & ~oclk_s3_q) : 1'b1;

  // output data register
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_q <= `EBR_DOUT_RST;
    end else if (out_tick) begin
      dout_q <= rd_word;
    end
  end

  assign rd_data_o = (REG_DOUT != 0) ? dout_q : rd_word;

endmodule // ebr_top

// ---- bench/ebr_user.sv ----
`timescale 1ns/1ns
// user logic model: every strobe launched from the block clock
module ebr_user (
  input wire logic clk_i,
  output logic cs_o,
  output logic we_o,
  output logic [10:0] a_o,
  output logic [7:0] d_o,
  output logic l_o,
  output logic [7:0] la_o,
  output logic [7:0] ld_o
);
  initial {cs_o, we_o, a_o, d_o, l_o, la_o, ld_o} = '0;
  // one access per edge, held until the next call
  task automatic step(input logic c, w, input logic [10:0] a, input logic [7:0] d,
                      input logic l = 0, input logic [7:0] la = 0, ld = 0);
    @(posedge clk_i);
    {cs_o, we_o, a_o, d_o, l_o, la_o, ld_o} <= {c, w, a, d, l, la, ld};
  endtask
endmodule // ebr_user

// ---- bench/ebr_top_assertions.sv ----
`timescale 1ns/1ns
// port checks for the ram block in its default set-up
module ebr_checker (
  input wire clk_i,
  input wire nrst_i,
  input wire cs_i,
  input wire we_i,
  input wire [10:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire cfg_load_i,
  input wire [7:0] cfg_addr_i,
  input wire [7:0] cfg_data_i,
  input wire [7:0] rd_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // user write and repeated read cycles
  sequence s_wr; cs_i && we_i && !cfg_load_i; endsequence
  sequence s_wr2; cs_i && we_i && !cfg_load_i && $stable(wr_addr_i); endsequence
  sequence s_rd; cs_i && !we_i && !cfg_load_i && $stable(wr_addr_i); endsequence
  sequence s_ld_rd; cs_i && !we_i && !cfg_load_i && $stable(wr_addr_i)
    && wr_addr_i[7:0] == $past(cfg_addr_i); endsequence
  AST_WR_RD: assert property (s_wr ##1 s_rd
    |-> ##2 rd_data_o == $past(wr_data_i, 3))
    else $error("write then read mismatch");
  AST_OLD: assert property (s_wr ##1 s_wr2
    |-> ##2 rd_data_o == $past(wr_data_i, 3))
    else $error("old word not seen first");
  AST_CFG: assert property (cfg_load_i ##1 s_ld_rd
    |-> ##2 rd_data_o == $past(cfg_data_i, 3))
    else $error("loaded row not read");
  AST_PRIO: assert property (s_wr ##1 (cfg_load_i && cs_i && !we_i && $stable(wr_addr_i)
    && cfg_addr_i == wr_addr_i[7:0]) |-> ##2 rd_data_o == $past(cfg_data_i, 2))
    else $error("load lost to write");
  AST_DESEL: assert property (!cs_i |-> ##2 rd_data_o == 8'h00)
    else $error("deselected output not zero");
  AST_REL: assert property ($rose(nrst_i) |-> rd_data_o == 8'h00)
    else $error("output not cleared by reset");
  AST_HOLD: assert property (
    (!we_i && !cfg_load_i && $stable(cs_i) && $stable(wr_addr_i))[*3] |=> $stable(rd_data_o))
    else $error("output moved without cause");
  AST_SEL_LAT: assert property (rd_data_o != 8'h00 |-> $past(cs_i, 2))
    else $error("output early");
endmodule // ebr_checker
bind ebr_top ebr_checker ebr_checker_i (.*);

// ---- bench/ebr_top_test.sv ----
`timescale 1ns/1ns
// self-checking bench for the ram block
module ebr_top_test;
  logic clk_i = 0;
  logic nrst_i = 0;
  logic cs, we, ld;
  logic [10:0] ad;
  logic [7:0] dt, la, lv;
  wire [7:0] rd;
  int num_errors = 0;
  int checks = 0;
  // ordinary rows: address above data
  logic [18:0] rows [3] = '{19'h00055, 19'h7ff3c, 19'h0ffaa};
  always #10 clk_i = ~clk_i;
  ebr_user ebr_user_i (.clk_i(clk_i), .cs_o(cs), .we_o(we), .a_o(ad), .d_o(dt),
    .l_o(ld), .la_o(la), .ld_o(lv));
  ebr_top ebr_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .out_clk_i(1'b0), .cs_i(cs),
    .we_i(we), .wr_addr_i(ad), .rd_addr_i(11'h000), .wr_data_i(dt), .cfg_load_i(ld),
    .cfg_addr_i(la), .cfg_data_i(lv), .rd_data_o(rd));
  // compare the output n edges on
  task automatic chk(input int n, input logic [7:0] e);
    repeat (n) @(posedge clk_i);
    #1;
    checks++;
    if (rd !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, rd, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1;
    foreach (rows[i]) begin
      ebr_user_i.step(1, 1, rows[i][18:8], rows[i][7:0]);
      ebr_user_i.step(1, 0, rows[i][18:8], 0);
      chk(2, rows[i][7:0]);
    end
    // back-to-back writes to one row
    ebr_user_i.step(1, 1, 11'h042, 8'h11);
    ebr_user_i.step(1, 1, 11'h042, 8'h22);
    ebr_user_i.step(1, 0, 11'h042, 0);
    chk(2, 8'h22);
    // row load, then a load racing a user write
    ebr_user_i.step(0, 0, 11'h0c3, 0, 1, 8'hc3, 8'h5a);
    ebr_user_i.step(1, 0, 11'h0c3, 0);
    chk(2, 8'h5a);
    ebr_user_i.step(1, 1, 11'h0c3, 8'hee);
    ebr_user_i.step(1, 0, 11'h0c3, 0, 1, 8'hc3, 8'ha5);
    chk(2, 8'ha5);
    // deselect, then reset in mid-run keeps the array
    ebr_user_i.step(0, 0, 11'h0c3, 0);
    chk(2, 8'h00);
    @(posedge clk_i) nrst_i <= 0;
    chk(1, 8'h00);
    @(posedge clk_i) nrst_i <= 1;
    ebr_user_i.step(1, 0, 11'h0c3, 0);
    chk(2, 8'ha5);
    close_out;
  end
  // watchdog against a hang
  initial begin
    #20000;
    num_errors++;
    close_out;
  end
endmodule // ebr_top_test
